// ### src/stz_core.sv
`timescale 1ns/10ps
module stz_core
    import stz_pkg::*;
#(
    parameter int POS_W = 24
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Configuration
    input wire stz_pkg::stz_cfg_t cfg_i,
    // Host pins
    input wire logic run_i,
    input wire logic mode_sw_i,
    input wire logic hold_cmd_i,
    input wire stz_pkg::stz_analog_t ain_i,
    input wire logic signed [15:0] freq_ref_i,
    input wire logic signed [15:0] torque_fb_i,
    // Encoder
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    // Results
    output logic torque_mode_o,
    output logic signed [15:0] torque_ref_o,
    output logic signed [15:0] torque_lim_o,
    output logic signed [15:0] speed_ref_o,
    output logic signed [15:0] hold_torque_o,
    output logic hold_active_o,
    output logic hold_done_o,
    output logic signed [15:0] hold_deviation_monitor_o,
    output logic drive_out_en_o
);
    import stz_pkg::*;

    if (POS_W < 16 || POS_W > 32) begin
        $error("stz_core: POS_W out of range");
    end

    typedef struct packed {
        logic [1:0] msw_s;
        logic [1:0] run_s;
        logic [1:0] hold_s;
        logic [1:0] a_s;
        logic [1:0] b_s;
        logic msw_p;
        logic a_p;
        logic b_p;
        stz_mode_e mode;
        logic [15:0] dly;
        logic pend_torque;
        stz_analog_t frz;
        logic [15:0] ms_cnt;
        logic [3:0] droop_cnt;
        logic signed [POS_W-1:0] pos;
        logic signed [POS_W-1:0] cap;
        logic hold_act;
        logic torque_mode;
        logic signed [15:0] tref;
        logic signed [15:0] tlim;
        logic signed [15:0] sref;
        logic signed [15:0] htq;
        logic done;
        logic signed [15:0] dev;
        logic out_en;
    } stz_state_t;

    stz_state_t s_q;
    stz_state_t s_d;
    logic tick_ms;
    logic droop_tick;
    logic signed [15:0] tref_raw;
    logic signed [15:0] tref_filt;
    logic signed [15:0] droop_raw;
    logic signed [15:0] droop_filt;

    // Live analog values unless the mode delay is running
    stz_analog_t ain_eff;
    logic switch_en;
    logic msw_edge;
    logic signed [15:0] comp;
    logic signed [31:0] droop_prod;
    logic signed [POS_W-1:0] dev_full;
    logic signed [POS_W+8:0] stiff;
    logic signed [15:0] fabs;
    logic [1:0] q_old;
    logic [1:0] q_new;
    // One bit wider than the count so the band never reads as negative
    logic signed [POS_W:0] band;

    always_comb begin
        switch_en = cfg_i.digital_input_function_select == DIN_FN_MODE &&
                    cfg_i.control_mode_select == CTRL_SEL_SWITCH;
        msw_edge = s_q.msw_s[1] ^ s_q.msw_p;
        ain_eff = (s_q.mode == ST_WAIT) ? s_q.frz : ain_i;
        comp = '0;
        if (cfg_i.aux_analog_function_select == AUX_FN_COMP) begin
            // Sign is direction; unipolar clamps reverse away
            comp = ain_eff.ain_two;
            if (!cfg_i.aux_bipolar && comp < 0) begin
                comp = '0;
            end
        end
        tref_raw = ain_eff.ain_one + comp;
        droop_prod = torque_fb_i * cfg_i.droop_gain;
        droop_raw = cfg_i.droop_enable_param ?
                    16'(droop_prod >>> 12) : 16'sh0000;
        fabs = freq_ref_i < 0 ? -freq_ref_i : freq_ref_i;
        dev_full = s_q.pos - s_q.cap;
        stiff = (POS_W+9)'(dev_full) *
                $signed({1'b0, cfg_i.hold_loop_gain});
        band = (POS_W+1)'(cfg_i.hold_completion_width);
    end

    assign tick_ms = s_q.ms_cnt == MS_CYC - 16'h0001;
    assign droop_tick = tick_ms && s_q.droop_cnt == 4'h0;

    stz_lpf #(.W(16)) u_tref_lpf (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(tick_ms),
        .shift_i(cfg_i.torque_ref_filter_time),
        .x_i(tref_raw),
        .y_o(tref_filt)
    );

    stz_lpf #(.W(16)) u_droop_lpf (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(droop_tick),
        .shift_i(cfg_i.droop_delay_time),
        .x_i(droop_raw),
        .y_o(droop_filt)
    );

    always_comb begin
        s_d = s_q;
        s_d.msw_s = {s_q.msw_s[0], mode_sw_i};
        s_d.run_s = {s_q.run_s[0], run_i};
        s_d.hold_s = {s_q.hold_s[0], hold_cmd_i};
        s_d.a_s = {s_q.a_s[0], enc_a_i};
        s_d.b_s = {s_q.b_s[0], enc_b_i};
        s_d.msw_p = s_q.msw_s[1];
        s_d.a_p = s_q.a_s[1];
        s_d.b_p = s_q.b_s[1];
        s_d.ms_cnt = tick_ms ? 16'h0000 : s_q.ms_cnt + 16'h0001;
        if (droop_tick) begin
            s_d.droop_cnt = 4'(DROOP_DELAY_MS / 10 - 1);
        end else if (tick_ms) begin
            s_d.droop_cnt = s_q.droop_cnt - 4'h1;
        end

        // Quadrature decoder, every edge counts
        q_old = {s_q.a_p, s_q.b_p};
        q_new = {s_q.a_s[1], s_q.b_s[1]};
        unique case ({q_old, q_new})
            4'b0001, 4'b0111, 4'b1110, 4'b1000:
                s_d.pos = s_q.pos + POS_W'(1);
            4'b0010, 4'b1011, 4'b1101, 4'b0100:
                s_d.pos = s_q.pos - POS_W'(1);
            default: s_d.pos = s_q.pos;
        endcase

        // Mode switch state machine
        unique case (s_q.mode)
            ST_SPEED, ST_TORQUE: begin
                if (switch_en && msw_edge) begin
                    s_d.frz = ain_i;
                    s_d.dly = cfg_i.mode_switch_delay;
                    s_d.pend_torque = s_q.msw_s[1];
                    s_d.mode = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (msw_edge) begin
                    // Restart on every edge, keep first freeze
                    s_d.dly = cfg_i.mode_switch_delay;
                    s_d.pend_torque = s_q.msw_s[1];
                end else if (s_q.dly == 16'h0000) begin
                    s_d.mode = s_q.pend_torque ? ST_TORQUE : ST_SPEED;
                end else if (tick_ms) begin
                    s_d.dly = s_q.dly - 16'h0001;
                end
            end
            default: s_d.mode = ST_SPEED;
        endcase
        if (!switch_en) begin
            s_d.mode = ST_SPEED;
        end
        if (!s_q.run_s[1]) begin
            s_d.mode = ST_SPEED;
        end

        s_d.torque_mode = s_q.mode == ST_TORQUE && s_q.run_s[1];
        if (s_d.torque_mode) begin
            s_d.tref = tref_filt;
            s_d.tlim = 16'sh7FFF;
        end else begin
            s_d.tref = 16'sh0000;
            s_d.tlim = ain_eff.ain_one;
        end
        // Run off: ramp target zero
        if (!s_q.run_s[1]) begin
            s_d.sref = 16'sh0000;
        end else begin
            // Disable drops the settled correction at once, not on a tick
            s_d.sref = freq_ref_i -
                       (cfg_i.droop_enable_param ?
                        droop_filt : 16'sh0000);
        end

        // Zero-servo hold
        if (s_q.hold_s[1] && s_q.run_s[1] &&
            cfg_i.digital_input_function_select == DIN_FN_HOLD &&
            cfg_i.control_method == CTRL_CLV &&
            16'(fabs) < cfg_i.zero_speed_level) begin
            if (!s_q.hold_act) begin
                s_d.cap = s_q.pos;
            end
            s_d.hold_act = 1'b1;
        end else begin
            s_d.hold_act = 1'b0;
        end
        s_d.htq = s_q.hold_act ? -16'(stiff >>> 4) : 16'sh0000;
        s_d.dev = s_q.hold_act ? 16'(dev_full) : 16'sh0000;
        s_d.done = s_q.hold_act && s_q.hold_s[1] &&
                   cfg_i.digital_output_function_select == DOUT_FN_DONE &&
                   (POS_W+1)'(dev_full) <= band &&
                   (POS_W+1)'(dev_full) >= -band;
        if (!s_q.hold_s[1]) begin
            s_d.done = 1'b0;
        end
        s_d.out_en = s_q.run_s[1];
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.mode <= ST_SPEED;
        end else begin
            s_q <= s_d;
        end
    end

    assign torque_mode_o = s_q.torque_mode;
    assign torque_ref_o = s_q.tref;
    assign torque_lim_o = s_q.tlim;
    assign speed_ref_o = s_q.sref;
    assign hold_torque_o = s_q.htq;
    assign hold_active_o = s_q.hold_act;
    assign hold_done_o = s_q.done;
    assign hold_deviation_monitor_o = s_q.dev;
    assign drive_out_en_o = s_q.out_en;

    run_forces_speed_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !s_q.run_s[1] |=> !torque_mode_o)
        else $error("torque mode with run off");
    done_drops_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !s_q.hold_s[1] |=> !hold_done_o)
        else $error("done high without command");
    hold_needs_run_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !s_q.run_s[1] |=> !hold_active_o)
        else $error("hold active with run off");
    freeze_hold_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) s_q.mode == ST_WAIT && $stable(s_q.mode)
        |-> $stable(s_q.frz)) else $error("frozen analog moved");
    edge_waits_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) switch_en && msw_edge && s_q.run_s[1]
        && cfg_i.mode_switch_delay != 16'h0000 |=> s_q.mode == ST_WAIT)
        else $error("mode change without delay");
    done_in_band_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) hold_done_o |-> $past(s_q.hold_act) &&
        hold_deviation_monitor_o <= band &&
        hold_deviation_monitor_o >= -band)
        else $error("done without hold or outside band");
    droop_off_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) s_q.run_s[1] && !cfg_i.droop_enable_param
        |=> speed_ref_o == $past(freq_ref_i))
        else $error("droop active while disabled");
    comp_unipolar_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) cfg_i.aux_analog_function_select ==
        AUX_FN_COMP && !cfg_i.aux_bipolar |-> comp >= 16'sh0000)
        else $error("reverse compensation on unipolar input");
    lim_in_speed_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) s_q.mode == ST_SPEED
        |=> torque_lim_o == $past(ain_i.ain_one))
        else $error("torque limit not from analog in speed mode");
    commit_after_wait_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) s_q.mode == ST_WAIT && s_q.dly == 16'h0000
        && !msw_edge |=> s_q.mode != ST_WAIT)
        else $error("expired mode delay not committed");
    torque_needs_fn_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !switch_en |-> ##2 !torque_mode_o)
        else $error("torque mode without switch function");
    cap_holds_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) hold_active_o && $past(hold_active_o)
        |-> $stable(s_q.cap)) else $error("capture moved during hold");
    idle_outputs_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !hold_active_o
        |=> hold_deviation_monitor_o == 16'sh0000 &&
        hold_torque_o == 16'sh0000)
        else $error("hold outputs nonzero while idle");
    out_follows_run_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) drive_out_en_o |-> $past(s_q.run_s[1]))
        else $error("output enabled without run");
endmodule

// ### shared/stz_pkg.sv
// Notes on behaviour
// - Torque reference passes a first-order low-pass with programmable time constant.
// - Analog input with function code 14 is summed as torque compensation.
// - Compensation sign gives direction: positive forward, negative reverse.
// - Unipolar compensation input accepts only forward; reverse needs bipolar level.
// - Input code 71 with mode select 0: low speed control, high torque.
// - Mode change takes effect only after programmable delay from either edge; here torque mode drops on the edge, only entry to torque waits.
// - Both analog inputs frozen at edge samples during the mode delay.
// - Shared analog input is torque limit in speed mode, reference in torque.
// - Run command off forces speed control and ramps the motor to stop; here speed_ref_o steps to zero and drive_out_en_o drops at once.
// - Speed reduced in proportion to torque by droop gain, default zero.
// - Droop disabled entirely when droop enable parameter is zero.
// - Droop correction filtered with delay time, default 0.05 s.
// - Zero-servo command on input code 72, only in closed-loop vector.
// - Zero-servo with reference below zero-speed level holds capture position.
// - Output code 33 high while position within start plus/minus width.
// - Completion width and deviation monitor count quadrature edges.
// - Completion output drops whenever the zero-servo command is off.
// - Run off cuts output and deactivates zero-servo; host keeps run on.
// - Holding stiffness scales with zero-servo gain, default 5.
package stz_pkg;
    localparam int DW = 16;
    localparam logic [7:0] AUX_FN_COMP = 8'h0E;
    localparam logic [7:0] DIN_FN_MODE = 8'h47;
    localparam logic [7:0] DIN_FN_HOLD = 8'h48;
    localparam logic [7:0] DOUT_FN_DONE = 8'h21;
    localparam logic [1:0] CTRL_SEL_SWITCH = 2'h0;
    localparam logic [1:0] CTRL_CLV = 2'h3;
    localparam logic [15:0] HOLD_WIDTH_RST = 16'h000A;
    localparam logic [7:0] HOLD_GAIN_RST = 8'h05;
    localparam logic [15:0] DROOP_GAIN_RST = 16'h0000;
    localparam logic [15:0] ZERO_LEVEL_RST = 16'h0032;
    localparam logic [3:0] FILT_SHIFT_RST = 4'h4;
    // Droop delay 0.05 s in ms; the droop filter ticks every tenth of it, 5 ms
    localparam int DROOP_DELAY_MS = 50;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_CYC = CLK_HZ / 1000;
    localparam logic [15:0] MS_CYC = 16'(TICK_CYC);

    typedef struct packed {
        logic signed [15:0] ain_one;
        logic signed [15:0] ain_two;
    } stz_analog_t;

    typedef struct packed {
        logic [7:0] aux_analog_function_select;
        logic aux_bipolar;
        logic [7:0] digital_input_function_select;
        logic [7:0] digital_output_function_select;
        logic [1:0] control_mode_select;
        logic [1:0] control_method;
        logic [15:0] mode_switch_delay;
        logic [3:0] torque_ref_filter_time;
        logic signed [15:0] droop_gain;
        logic droop_enable_param;
        logic [3:0] droop_delay_time;
        logic [15:0] zero_speed_level;
        logic [7:0] hold_loop_gain;
        logic [15:0] hold_completion_width;
    } stz_cfg_t;

    typedef enum logic [2:0] {
        ST_SPEED = 3'b001,
        ST_WAIT = 3'b010,
        ST_TORQUE = 3'b100
    } stz_mode_e;
endpackage

// ### src/stz_lpf.sv
`timescale 1ns/10ps
// First-order shift filter, one step per enable pulse
module stz_lpf #(
    parameter int W = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [3:0] shift_i,
    input wire logic signed [W-1:0] x_i,
    output logic signed [W-1:0] y_o
);
    logic signed [W+15:0] acc_q;
    logic signed [W+15:0] acc_d;
    logic signed [W+15:0] err;

    always_comb begin
        err = (W+16)'(x_i) - (acc_q >>> 16);
        acc_d = acc_q;
        if (en_i) begin
            // Larger shift = slower response, less noise
            acc_d = acc_q + ((err <<< 16) >>> shift_i);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign y_o = acc_q[W+15:16];
endmodule

// ### bench/stz_enc_model.sv
`timescale 1ns/10ps
// Quadrature encoder on the rotor shaft, moved on request
module stz_enc_model (
    input wire logic core_clk_i,
    output logic enc_a_o,
    output logic enc_b_o
);
    logic [1:0] ph;

    initial ph = 2'h0;
    // Gray order, so only one line changes per step
    assign enc_a_o = ph[1];
    assign enc_b_o = ph[1] ^ ph[0];

    // Each step stands four cycles so the input sync sees it
    task automatic move(input int n);
        int k;
        for (k = 0; k < (n < 0 ? -n : n); k++) begin
            @(negedge core_clk_i);
            ph = (n < 0) ? ph - 2'h1 : ph + 2'h1;
            repeat (3) @(negedge core_clk_i);
        end
    endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import stz_pkg::*;
    logic core_clk_i, rst_n_i, run_i, mode_sw_i, hold_cmd_i, enc_a, enc_b;
    stz_cfg_t cfg;
    stz_analog_t ain;
    logic signed [15:0] freq_ref, torque_ref, hold_torque, dev;
    logic signed [15:0] speed_ref, torque_lim, torque_fb;
    logic torque_mode, hold_active, hold_done, out_en;
    int failures, checked;

    stz_core i_stz_core (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
        .run_i(run_i), .mode_sw_i(mode_sw_i), .hold_cmd_i(hold_cmd_i),
        .ain_i(ain), .freq_ref_i(freq_ref), .torque_fb_i(torque_fb),
        .enc_a_i(enc_a), .enc_b_i(enc_b), .torque_mode_o(torque_mode),
        .torque_ref_o(torque_ref), .torque_lim_o(torque_lim),
        .speed_ref_o(speed_ref),
        .hold_torque_o(hold_torque), .hold_active_o(hold_active),
        .hold_done_o(hold_done), .hold_deviation_monitor_o(dev),
        .drive_out_en_o(out_en)
    );
    stz_enc_model i_stz_enc_model (
        .core_clk_i(core_clk_i), .enc_a_o(enc_a), .enc_b_o(enc_b)
    );

    task automatic test_done();
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    function automatic logic [15:0] mag(input logic signed [15:0] v);
        return (v < 0) ? -v : v;
    endfunction

    task automatic wait_mode(input logic v, input int lim);
        int k;
        for (k = 0; k < lim && torque_mode !== v; k++)
            cyc(1);
        chk("torque_mode_o", {15'h0000, v}, {15'h0000, torque_mode});
        if (torque_mode !== v)
            test_done();
    endtask

    // Restarted delay, then compensation in torque mode, then run off
    task automatic sc_mode();
        run_i = 1'b1;
        freq_ref = 16'sh0400;
        cyc(20);
        chk("speed_ref_o", 16'h0400, speed_ref);
        mode_sw_i = 1'b1;
        cyc(15000);
        mode_sw_i = 1'b0;
        cyc(100);
        mode_sw_i = 1'b1;
        cyc(17900);
        chk("torque_mode_o", 16'h0000, {15'h0000, torque_mode});
        chk("speed_ref_o", 16'h0300, speed_ref);
        ain.ain_one = 16'sh0200;
        cyc(5);
        chk("torque_lim_o", 16'h03E8, torque_lim);
        ain.ain_one = 16'sh03E8;
        cfg.droop_enable_param = 1'b0;
        cyc(2);
        chk("speed_ref_o", 16'h0400, speed_ref);
        wait_mode(1'b1, 13000);
        cyc(10100);
        chk("torque_ref_o", 16'h02BC, torque_ref);
        cfg.aux_bipolar = 1'b0;
        cyc(10100);
        chk("torque_ref_o", 16'h03E8, torque_ref);
        run_i = 1'b0;
        cyc(8);
        chk("torque_mode_o", 16'h0000, {15'h0000, torque_mode});
        chk("drive_out_en_o", 16'h0000, {15'h0000, out_en});
        chk("speed_ref_o", 16'h0000, speed_ref);
    endtask

    task automatic sc_hold();
        cfg.digital_input_function_select = DIN_FN_HOLD;
        cfg.mode_switch_delay = 16'h0001;
        cfg.control_method = 2'h2;
        freq_ref = 16'sh0000;
        run_i = 1'b1;
        mode_sw_i = 1'b0;
        hold_cmd_i = 1'b1;
        cyc(10);
        chk("hold_active_o", 16'h0000, {15'h0000, hold_active});
        cfg.control_method = CTRL_CLV;
        freq_ref = 16'sh0064;
        cyc(10);
        chk("hold_active_o", 16'h0000, {15'h0000, hold_active});
        freq_ref = 16'sh0000;
        cyc(10);
        chk("hold_active_o", 16'h0001, {15'h0000, hold_active});
        chk("hold_done_o", 16'h0001, {15'h0000, hold_done});
        i_stz_enc_model.move(12);
        cyc(10);
        chk("hold_deviation_monitor_o", 16'h000C, mag(dev));
        chk("hold_done_o", 16'h0000, {15'h0000, hold_done});
        chk("hold_torque_o", 16'h000C, mag(hold_torque));
        i_stz_enc_model.move(-2);
        cyc(10);
        chk("hold_deviation_monitor_o", 16'h000A, mag(dev));
        chk("hold_done_o", 16'h0001, {15'h0000, hold_done});
        hold_cmd_i = 1'b0;
        cyc(10);
        chk("hold_done_o", 16'h0000, {15'h0000, hold_done});
        hold_cmd_i = 1'b1;
        mode_sw_i = 1'b1;
        cyc(10);
        chk("hold_deviation_monitor_o", 16'h0000, dev);
        // Wrong input function, so the mode pin must be ignored
        ain.ain_one = 16'sh0123;
        cyc(10100);
        chk("torque_mode_o", 16'h0000, {15'h0000, torque_mode});
        chk("torque_lim_o", 16'h0123, torque_lim);
        run_i = 1'b0;
        cyc(10);
        chk("hold_active_o", 16'h0000, {15'h0000, hold_active});
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    initial begin
        failures = 0;
        checked = 0;
        rst_n_i = 1'b0;
        run_i = 1'b0;
        mode_sw_i = 1'b0;
        hold_cmd_i = 1'b0;
        freq_ref = 16'sh0000;
        ain.ain_one = 16'sh03E8;
        ain.ain_two = -16'sh012C;
        cfg = '0;
        cfg.aux_analog_function_select = AUX_FN_COMP;
        cfg.aux_bipolar = 1'b1;
        cfg.digital_input_function_select = DIN_FN_MODE;
        cfg.digital_output_function_select = DOUT_FN_DONE;
        cfg.control_mode_select = CTRL_SEL_SWITCH;
        cfg.mode_switch_delay = 16'h0003;
        torque_fb = 16'sh0100;
        cfg.droop_gain = 16'sh1000;
        cfg.droop_enable_param = 1'b1;
        cfg.zero_speed_level = ZERO_LEVEL_RST;
        cfg.hold_loop_gain = 8'h10;
        cfg.hold_completion_width = HOLD_WIDTH_RST;
        cyc(2);
        chk("torque_mode_o", 16'h0000, {15'h0000, torque_mode});
        chk("hold_done_o", 16'h0000, {15'h0000, hold_done});
        rst_n_i = 1'b1;
        sc_mode();
        sc_hold();
        test_done();
    end
endmodule
